// ### include/uart_ctl_pkg.sv
// package: register map, field positions, reset values and modes of the uart control block
package uart_ctl_pkg;

    localparam logic [11:0] CTRL_OFFSET     = 12'h0014;
    localparam logic [11:0] EVENT_OFFSET    = 12'h0024;
    localparam logic [11:0] STATUS_OFFSET   = 12'h0028;

    localparam int          EOF_LSB         = 21;
    localparam int          EOF_MSB         = 27;
    localparam int          KEEP_BIT        = 20;
    localparam int          MODE_LSB        = 18;
    localparam int          MODE_MSB        = 19;
    localparam int          WAKE_LSB        = 16;
    localparam int          WAKE_MSB        = 17;
    localparam int          REPLAY_BIT      = 15;
    localparam int          STOP_BIT        = 14;
    localparam int          TXINC_BIT       = 13;
    localparam int          DIV_MSB         = 12;

    localparam logic [31:0] CTRL_RESET      = 32'h0201_0000;
    localparam logic [31:0] CTRL_WMASK      = 32'h0FFF_FFFF;
    localparam logic [6:0]  EOF_RESET       = 7'h10;
    localparam logic [1:0]  WAKE_RESET      = 2'h1;

    typedef enum logic [1:0]
    {
        EST_OFF    = 2'b00,
        EST_AUTO   = 2'b01,
        EST_REPORT = 2'b10,
        EST_RSVD   = 2'b11
    } est_mode_t;

    typedef enum logic [1:0]
    {
        EV_ESTIMATE = 2'd0,
        EV_STANDBY  = 2'd1,
        EV_WAKE     = 2'd2
    } ev_bit_t;

    // divider used for transmit bit timing
    function automatic logic [13:0] tx_div(input logic [12:0] rx, input logic inc);
        tx_div = {1'b0, rx} + {13'h0000, inc};
    endfunction

endpackage

// ### include/uart_cfg_if.sv
// interface: configuration fields passed from the register file to the datapath
interface uart_cfg_if;
    logic [6:0]  end_of_frame_gap_bits;
    logic        keep_estimation_byte;
    logic [1:0]  baud_estimator_mode;
    logic [1:0]  wakeup_lost_byte_count;
    logic        standby_wakeup_replay;
    logic        two_stop_bits;
    logic        tx_divider_increment;
    logic [12:0] rx_sample_divider;
    logic        est_valid;
    logic [12:0] est_divider;
    logic        est_apply;
    logic        replay_done;

    modport regs
    (
        output end_of_frame_gap_bits, keep_estimation_byte, baud_estimator_mode,
        output wakeup_lost_byte_count, standby_wakeup_replay, two_stop_bits,
        output tx_divider_increment, rx_sample_divider, est_apply,
        input  est_valid, est_divider, replay_done
    );
    modport core
    (
        input  end_of_frame_gap_bits, keep_estimation_byte, baud_estimator_mode,
        input  wakeup_lost_byte_count, standby_wakeup_replay, two_stop_bits,
        input  tx_divider_increment, rx_sample_divider, est_apply,
        output est_valid, est_divider, replay_done
    );
endinterface

// ### rtl/uart_bit_timer.sv
// bit timer: one-cycle bit tick from a programmable clock divider
module uart_bit_timer
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic [13:0] divide,
    output logic             tick
);
    logic [13:0] count;
    logic [13:0] next_count;

    always_comb
    begin
        next_count = count;
        tick       = 1'b0;
        if (!run)
        begin
            next_count = 14'h0000;
        end
        else if (count >= divide)
        begin
            next_count = 14'h0000;
            tick       = 1'b1;
        end
        else
        begin
            next_count = count + 14'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count <= 14'h0000;
        else
            count <= next_count;
    end
endmodule

// ### rtl/uart_ctl_regs.sv
// apb register file for the uart control word and status
module uart_ctl_regs
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [2:0]  events,
    input  wire logic [31:0] status,
    uart_cfg_if.regs         cfg
);
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [2:0]  sticky;
    logic [2:0]  next_sticky;
    logic        wr;
    logic        hit;

    assign wr  = psel && penable && pwrite;
    assign hit = paddr == uart_ctl_pkg::CTRL_OFFSET || paddr == uart_ctl_pkg::EVENT_OFFSET
                 || paddr == uart_ctl_pkg::STATUS_OFFSET;
    assign pslverr = psel && penable && !hit;

    always_comb
    begin
        next_ctrl   = ctrl;
        next_sticky = sticky;
        if (wr && paddr == uart_ctl_pkg::CTRL_OFFSET)
            next_ctrl = pwdata & uart_ctl_pkg::CTRL_WMASK;
        if (wr && paddr == uart_ctl_pkg::EVENT_OFFSET)
            next_sticky = sticky & ~pwdata[2:0];
        // estimate applied into the divider in auto mode only
        if (cfg.est_apply && cfg.est_valid)
            next_ctrl[uart_ctl_pkg::DIV_MSB:0] = cfg.est_divider;
        // replay control is single shot: cleared after use
        if (cfg.replay_done)
            next_ctrl[uart_ctl_pkg::REPLAY_BIT] = 1'b0;
        next_sticky = next_sticky | events;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl   <= uart_ctl_pkg::CTRL_RESET;
            sticky <= 3'b000;
        end
        else
        begin
            ctrl   <= next_ctrl;
            sticky <= next_sticky;
        end
    end

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (psel && paddr == uart_ctl_pkg::CTRL_OFFSET)
            prdata = ctrl;
        else if (psel && paddr == uart_ctl_pkg::EVENT_OFFSET)
            prdata = {29'h0000_0000, sticky};
        else if (psel && paddr == uart_ctl_pkg::STATUS_OFFSET)
            prdata = status;
    end

    assign cfg.end_of_frame_gap_bits  = ctrl[uart_ctl_pkg::EOF_MSB:uart_ctl_pkg::EOF_LSB];
    assign cfg.keep_estimation_byte   = ctrl[uart_ctl_pkg::KEEP_BIT];
    assign cfg.baud_estimator_mode    = ctrl[uart_ctl_pkg::MODE_MSB:uart_ctl_pkg::MODE_LSB];
    assign cfg.wakeup_lost_byte_count = ctrl[uart_ctl_pkg::WAKE_MSB:uart_ctl_pkg::WAKE_LSB];
    assign cfg.standby_wakeup_replay  = ctrl[uart_ctl_pkg::REPLAY_BIT];
    assign cfg.two_stop_bits          = ctrl[uart_ctl_pkg::STOP_BIT];
    assign cfg.tx_divider_increment   = ctrl[uart_ctl_pkg::TXINC_BIT];
    assign cfg.rx_sample_divider      = ctrl[uart_ctl_pkg::DIV_MSB:0];
    assign cfg.est_apply              = ctrl[uart_ctl_pkg::MODE_MSB:uart_ctl_pkg::MODE_LSB]
                                        == uart_ctl_pkg::EST_AUTO;
endmodule

// ### rtl/host_uart_frame_control.sv
// top: uart framing, baud estimation and wakeup replay under the control word
//
// Function
// - end-of-frame gap is field plus one bits
// - bit 20 keeps or drops estimation byte
// - estimator mode: off, auto apply, report only
// - lost wakeup byte count, reset one
// - replay control injects lost wakeup bytes
// - replay happens once until re-armed
// - one or two stop bits framing
// - tx divider is rx divider plus increment
// - thirteen bit rx divider, reset zero
//
// The APB slave port was left to the implementer.
module host_uart_frame_control
(
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        RXD,
    input  wire logic        RTS,
    input  wire logic        STANDBY_EXIT,
    output logic             TXD,
    input  wire logic        TX_VALID,
    input  wire logic [7:0]  TX_DATA,
    output logic             TX_READY,
    output logic             RX_VALID,
    output logic [7:0]       RX_DATA,
    output logic             RX_LOST,
    output logic             FRAME_END
);
    uart_cfg_if cfg ();

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [1:0] rxd_sync;
    logic [1:0] rts_sync;
    logic [1:0] sby_sync;
    logic       rxd;
    logic       rts_prev;
    logic       sby_prev;
    logic       sby_rise;
    logic       rts_rise;

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rxd_sync <= 2'b11;
            rts_sync <= 2'b00;
            sby_sync <= 2'b00;
            rts_prev <= 1'b0;
            sby_prev <= 1'b0;
        end
        else
        begin
            rxd_sync <= {rxd_sync[0], RXD};
            rts_sync <= {rts_sync[0], RTS};
            sby_sync <= {sby_sync[0], STANDBY_EXIT};
            rts_prev <= rts_sync[1];
            sby_prev <= sby_sync[1];
        end
    end

    assign rxd      = rxd_sync[1];
    assign rts_rise = rts_sync[1] && !rts_prev;
    assign sby_rise = sby_sync[1] && !sby_prev;

    // ************************************************************
    // registers
    // ************************************************************
    logic [2:0]  events;
    logic [31:0] status;

    assign PREADY = 1'b1;

    uart_ctl_regs u_regs
    (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .psel    (PSEL),
        .penable (PENABLE),
        .pwrite  (PWRITE),
        .paddr   (PADDR),
        .pwdata  (PWDATA),
        .prdata  (PRDATA),
        .pslverr (PSLVERR),
        .events  (events),
        .status  (status),
        .cfg     (cfg)
    );

    // ************************************************************
    // bit timers
    // ************************************************************
    logic        rx_run;
    logic        rx_tick;
    logic        tx_run;
    logic        tx_tick;
    logic [13:0] tx_divide;

    assign tx_divide = uart_ctl_pkg::tx_div(cfg.rx_sample_divider, cfg.tx_divider_increment);

    uart_bit_timer u_rx_timer
    (
        .clk    (CLOCK),
        .rst_n  (RST_N),
        .run    (rx_run),
        .divide ({1'b0, cfg.rx_sample_divider}),
        .tick   (rx_tick)
    );

    uart_bit_timer u_tx_timer
    (
        .clk    (CLOCK),
        .rst_n  (RST_N),
        .run    (tx_run),
        .divide (tx_divide),
        .tick   (tx_tick)
    );

    // ************************************************************
    // receiver, estimation, gap and replay
    // ************************************************************
    typedef enum logic [1:0] {RX_IDLE, RX_DATA_ST, RX_STOP} rx_state_t;

    rx_state_t   rx_state;
    rx_state_t   next_rx_state;
    logic [3:0]  rx_bit;
    logic [3:0]  next_rx_bit;
    logic [7:0]  rx_shift;
    logic [7:0]  next_rx_shift;
    logic [7:0]  gap;
    logic [7:0]  next_gap;
    logic        est_first;
    logic        next_est_first;
    logic [12:0] est_cnt;
    logic [12:0] next_est_cnt;
    logic        est_valid;
    logic        next_est_valid;
    logic [12:0] est_div;
    logic [12:0] next_est_div;
    logic [1:0]  replay_left;
    logic [1:0]  next_replay_left;
    logic        rx_valid;
    logic        next_rx_valid;
    logic [7:0]  rx_data;
    logic [7:0]  next_rx_data;
    logic        lost;
    logic        next_lost;
    logic        frame_end;
    logic        next_frame_end;
    logic        replay_done;
    logic        est_on;

    // reserved mode counts as inactive
    assign est_on = cfg.baud_estimator_mode == uart_ctl_pkg::EST_AUTO
                    || cfg.baud_estimator_mode == uart_ctl_pkg::EST_REPORT;
    // timer held in reset while a start bit is seen, so each frame samples in its own phase
    assign rx_run = rx_state != RX_IDLE || (gap != 8'h00 && rxd);

    always_comb
    begin
        next_rx_state    = rx_state;
        next_rx_bit      = rx_bit;
        next_rx_shift    = rx_shift;
        next_gap         = gap;
        next_est_first   = est_first;
        next_est_cnt     = est_cnt;
        next_est_valid   = 1'b0;
        next_est_div     = est_div;
        next_replay_left = replay_left;
        next_rx_valid    = 1'b0;
        next_rx_data     = rx_data;
        next_lost        = 1'b0;
        next_frame_end   = 1'b0;
        replay_done      = 1'b0;
        if (!est_on)
            next_est_first = 1'b1;
        // replay armed at standby exit, used once
        if (sby_rise && cfg.standby_wakeup_replay)
        begin
            next_replay_left = cfg.wakeup_lost_byte_count;
            replay_done      = 1'b1;
        end
        else if (replay_left != 2'b00)
        begin
            next_replay_left = replay_left - 2'b01;
            next_rx_valid    = 1'b1;
            next_rx_data     = 8'h00;
        end
        unique case (rx_state)
            RX_IDLE:
            begin
                if (!rxd)
                begin
                    next_rx_state = RX_DATA_ST;
                    next_rx_bit   = 4'h0;
                    next_est_cnt  = 13'h0000;
                    next_gap      = 8'h00;
                end
                else if (rx_tick && gap != 8'h00)
                begin
                    // gap spans field plus one bit times
                    if (gap == {1'b0, cfg.end_of_frame_gap_bits} + 8'h01)
                    begin
                        next_frame_end = 1'b1;
                        next_gap       = 8'h00;
                    end
                    else
                        next_gap = gap + 8'h01;
                end
            end
            RX_DATA_ST:
            begin
                if (est_first && est_on && rxd == 1'b0)
                    next_est_cnt = est_cnt + 13'h0001;
                if (rx_tick)
                begin
                    next_rx_shift = {rxd, rx_shift[7:1]};
                    next_rx_bit   = rx_bit + 4'h1;
                    if (rx_bit == 4'h7)
                        next_rx_state = RX_STOP;
                end
            end
            RX_STOP:
            begin
                if (rx_tick)
                begin
                    next_rx_state = RX_IDLE;
                    next_gap      = 8'h01;
                    if (est_first && est_on)
                    begin
                        next_est_first = 1'b0;
                        next_est_valid = 1'b1;
                        next_est_div   = est_cnt;
                        next_rx_valid  = cfg.keep_estimation_byte;
                    end
                    else
                        next_rx_valid = 1'b1;
                    next_rx_data = rx_shift;
                    next_lost    = rxd == 1'b0;
                end
            end
            default:
                next_rx_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rx_state    <= RX_IDLE;
            rx_bit      <= 4'h0;
            rx_shift    <= 8'h00;
            gap         <= 8'h00;
            est_first   <= 1'b1;
            est_cnt     <= 13'h0000;
            est_valid   <= 1'b0;
            est_div     <= 13'h0000;
            replay_left <= 2'b00;
            rx_valid    <= 1'b0;
            rx_data     <= 8'h00;
            lost        <= 1'b0;
            frame_end   <= 1'b0;
        end
        else
        begin
            rx_state    <= next_rx_state;
            rx_bit      <= next_rx_bit;
            rx_shift    <= next_rx_shift;
            gap         <= next_gap;
            est_first   <= next_est_first;
            est_cnt     <= next_est_cnt;
            est_valid   <= next_est_valid;
            est_div     <= next_est_div;
            replay_left <= next_replay_left;
            rx_valid    <= next_rx_valid;
            rx_data     <= next_rx_data;
            lost        <= next_lost;
            frame_end   <= next_frame_end;
        end
    end

    assign cfg.est_valid   = est_valid;
    assign cfg.est_divider = est_div;
    assign cfg.replay_done = replay_done;
    assign events = {rts_rise, sby_rise, est_valid};
    assign status = {19'h0_0000, est_div};
    assign RX_VALID  = rx_valid;
    assign RX_DATA   = rx_data;
    assign RX_LOST   = lost;
    assign FRAME_END = frame_end;

    // ************************************************************
    // transmitter
    // ************************************************************
    logic [10:0] tx_shift;
    logic [10:0] next_tx_shift;
    logic [3:0]  tx_left;
    logic [3:0]  next_tx_left;

    assign tx_run   = tx_left != 4'h0;
    assign TX_READY = tx_left == 4'h0;
    assign TXD      = tx_shift[0];

    always_comb
    begin
        next_tx_shift = tx_shift;
        next_tx_left  = tx_left;
        if (TX_VALID && tx_left == 4'h0)
        begin
            next_tx_shift = {2'b11, TX_DATA, 1'b0};
            next_tx_left  = cfg.two_stop_bits ? 4'hB : 4'hA;
        end
        else if (tx_tick)
        begin
            next_tx_shift = {1'b1, tx_shift[10:1]};
            next_tx_left  = tx_left - 4'h1;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tx_shift <= 11'h7FF;
            tx_left  <= 4'h0;
        end
        else
        begin
            tx_shift <= next_tx_shift;
            tx_left  <= next_tx_left;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_stop_done;
        rx_state == RX_STOP && rx_tick;
    endsequence

    a_tx_frame_len: assert property (@(posedge CLOCK) disable iff (!RST_N)
        TX_VALID && TX_READY |=> tx_left == (cfg.two_stop_bits ? 4'hB : 4'hA))
        else $error("tx frame length wrong");
    a_tx_divider: assert property (@(posedge CLOCK) disable iff (!RST_N)
        tx_divide == {1'b0, cfg.rx_sample_divider} + {13'h0000, cfg.tx_divider_increment})
        else $error("tx divider wrong");
    a_replay_once: assert property (@(posedge CLOCK) disable iff (!RST_N)
        replay_done |=> !cfg.standby_wakeup_replay)
        else $error("replay not disarmed");
    a_replay_load: assert property (@(posedge CLOCK) disable iff (!RST_N)
        replay_done |=> replay_left == $past(cfg.wakeup_lost_byte_count))
        else $error("replay count wrong");
    a_est_inactive: assert property (@(posedge CLOCK) disable iff (!RST_N)
        cfg.baud_estimator_mode == uart_ctl_pkg::EST_RSVD |=> !est_valid)
        else $error("reserved mode estimated");
    a_keep_byte: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_stop_done and est_first && est_on && replay_left == 2'b00 && !sby_rise
        |=> rx_valid == $past(cfg.keep_estimation_byte))
        else $error("estimation byte handling wrong");
    a_gap_end: assert property (@(posedge CLOCK) disable iff (!RST_N)
        frame_end |-> $past(gap) == {1'b0, $past(cfg.end_of_frame_gap_bits)} + 8'h01)
        else $error("gap end wrong");
    a_auto_apply: assert property (@(posedge CLOCK) disable iff (!RST_N)
        est_valid && cfg.est_apply |=> cfg.rx_sample_divider == $past(est_div))
        else $error("estimate not applied");
endmodule

// ### tb/uart_host_model.sv
// host-side serial model on the far end of the uart pins
module uart_host_model
(
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ns;

    initial rxd = 1'b1;

    // start, eight data bits lsb first, then stop bits high
    task automatic send(input logic [7:0] b, input int per, input int stops);
        logic [10:0] f;
        f = {2'b11, b, 1'b0};
        for (int i = 0; i < 9 + stops; i++)
            repeat (per) @(posedge clk) rxd <= f[i];
    endtask

    // decode one frame, sampling near the middle of each bit
    task automatic recv(input int per, output logic [7:0] b);
        int n;
        n = 0;
        while (txd !== 1'b0 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (per) @(posedge clk);
            b[i] = txd;
        end
    endtask
endmodule

// ### tb/tb.sv
// self-checking bench for the uart frame control block
`define CHK(a, b) check(32'(a), 32'(b))
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        rxd;
    logic        rts = 1'b0;
    logic        sbx = 1'b0;
    logic        txd;
    logic        txv = 1'b0;
    logic [7:0]  txb = 8'h00;
    logic        txr;
    logic        rxv;
    logic [7:0]  rxdat;
    logic        fe;
    logic        lst;
    int          lost_count = 0;
    int          bad_count = 0;
    int          compares = 0;

    always #5 clk = ~clk;

    always @(posedge clk)
        if (lst === 1'b1)
            lost_count++;

    host_uart_frame_control dut_u
    (
        .CLOCK(clk),
        .RST_N(rst_n),
        .PSEL(psel),
        .PENABLE(penable),
        .PWRITE(pwrite),
        .PADDR(paddr),
        .PWDATA(pwdata),
        .PRDATA(prdata),
        .PREADY(pready),
        .PSLVERR(pslverr),
        .RXD(rxd),
        .RTS(rts),
        .STANDBY_EXIT(sbx),
        .TXD(txd),
        .TX_VALID(txv),
        .TX_DATA(txb),
        .TX_READY(txr),
        .RX_VALID(rxv),
        .RX_DATA(rxdat),
        .RX_LOST(lst),
        .FRAME_END(fe)
    );

    uart_host_model host(.clk(clk), .txd(txd), .rxd(rxd));

    function automatic void check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endfunction

    task automatic summarize();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // control word with the rx divider fixed at 7
    function automatic logic [31:0] cw(input logic [6:0] g, input logic k, input logic [1:0] m,
                                       input logic [1:0] w, input logic r, input logic s, input logic i);
        return {4'h0, g, k, m, w, r, s, i, 13'h0007};
    endfunction

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            check(32'h0, 32'h1);
            summarize();
        end
    endtask

    task automatic count_rx(input int c, output int n, output logic [7:0] d);
        n = 0;
        d = 8'hFF;
        repeat (c)
        begin
            @(negedge clk);
            if (rxv === 1'b1)
            begin
                n++;
                d = rxdat;
            end
        end
    endtask

    task automatic t_regs();
        logic [31:0] q;
        apb(1'b0, 12'h014, 32'h0, q);
        `CHK(q, 32'h0201_0000);
        apb(1'b1, 12'h014, 32'hFFFF_FFFF, q);
        apb(1'b0, 12'h014, 32'h0, q);
        `CHK(q, 32'h0FFF_FFFF);
        apb(1'b0, 12'h030, 32'h0, q);
        `CHK(err, 1'b1);
        `CHK(q, 32'h0000_0000);
        $display("register test done");
    endtask

    task automatic t_tx();
        logic [31:0] q;
        logic [7:0]  b;
        int          n;
        int          e;
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, 12'h014, cw(7'h10, 1'b0, 2'b00, 2'h1, 1'b0, k[1], k[0]), q);
            txv <= 1'b1;
            txb <= 8'hA5 ^ 8'(k);
            @(posedge clk);
            txv <= 1'b0;
            n = 0;
            e = (10 + k / 2) * (8 + k % 2);
            fork
                host.recv(8 + k % 2, b);
                do
                begin
                    @(negedge clk);
                    n++;
                end
                while (txr !== 1'b1 && n < 400);
            join
            `CHK(b, 8'hA5 ^ 8'(k));
            `CHK(n >= e - 2 && n <= e + 2, 1);
        end
        $display("tx test done");
    endtask

    task automatic t_gap();
        logic [31:0] q;
        logic [7:0]  d;
        int          n;
        apb(1'b1, 12'h014, cw(7'h02, 1'b0, 2'b00, 2'h1, 1'b0, 1'b0, 1'b0), q);
        fork
            host.send(8'h3C, 8, 1);
            count_rx(90, n, d);
        join
        `CHK({n[7:0], d}, 16'h013C);
        n = 90;
        while (fe !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        `CHK(n >= 98 && n <= 120, 1);
        `CHK(lost_count, 0);
        host.send(8'h00, 8, 0);
        host.send(8'hFF, 8, 1);
        repeat (20) @(posedge clk);
        `CHK(lost_count != 0, 1);
        $display("rx gap test done");
    endtask

    task automatic t_est(input logic [1:0] m);
        logic [31:0] q;
        logic [31:0] s;
        logic [7:0]  d;
        int          n;
        do_reset();
        apb(1'b1, 12'h014, cw(7'h10, m == 2'b10, m, 2'h1, 1'b0, 1'b0, 1'b0), q);
        fork
            begin
                host.send(8'h00, 8, 1);
                if (m != 2'b01)
                    host.send(8'h55, 8, 1);
            end
            count_rx(200, n, d);
        join
        apb(1'b0, 12'h014, 32'h0, q);
        apb(1'b0, 12'h028, 32'h0, s);
        `CHK(n, m == 2'b01 ? 0 : 2);
        `CHK(q[12:0], m == 2'b01 ? s[12:0] : 13'h0007);
        if (m == 2'b01)
            `CHK(s[12:0] != 13'h0007, 1);
        $display("estimator test done");
    endtask

    task automatic t_replay();
        logic [31:0] q;
        logic [7:0]  d;
        int          n;
        for (int k = 0; k < 3; k++)
        begin
            if (k != 1)
                apb(1'b1, 12'h014, cw(7'h10, 1'b0, 2'b00, 2'(k / 2 + 2), 1'b1, 1'b0, 1'b0), q);
            @(posedge clk);
            sbx <= 1'b1;
            @(posedge clk);
            sbx <= 1'b0;
            count_rx(20, n, d);
            `CHK(n, k == 1 ? 0 : k / 2 + 2);
            if (k == 0)
                `CHK(d, 8'h00);
        end
        apb(1'b0, 12'h014, 32'h0, q);
        `CHK(q[15], 0);
        rts <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, 12'h024, 32'h0, q);
        `CHK(q[2], 1);
        $display("replay test done");
    endtask

    initial
    begin
        do_reset();
        t_regs();
        t_tx();
        t_gap();
        for (int m = 1; m < 4; m++)
            t_est(m[1:0]);
        t_replay();
        summarize();
    end
endmodule
